// ### src/occ_pkg.sv
package occ_pkg;

  // key slots of the synchroniser, one per console key
  localparam int unsigned KEY_N         = 12;
  localparam int unsigned K_PRESET      = 0;
  localparam int unsigned K_DO          = 1;
  localparam int unsigned K_START20     = 2;
  localparam int unsigned K_START400    = 3;
  localparam int unsigned K_LAUNCH      = 4;
  localparam int unsigned K_RESUME      = 5;
  localparam int unsigned K_VIEW        = 6;
  localparam int unsigned K_VIEW_NEXT   = 7;
  localparam int unsigned K_DEPOSIT     = 8;
  localparam int unsigned K_DEP_ADV     = 9;
  localparam int unsigned K_AUTO        = 10;
  localparam int unsigned K_STOP        = 11;

  // preset values
  localparam logic [4:0]  IF_PRESET     = 5'h02;
  localparam logic [4:0]  DF_PRESET     = 5'h03;
  localparam logic        MODE_RST      = 1'b1;

  // start locations: 20 and 400 octal
  localparam logic [9:0]  NAT_START20   = 10'h010;
  localparam logic [9:0]  NAT_START400  = 10'h100;
  localparam logic [14:0] CMP_START20   = 15'h0010;
  localparam logic [14:0] CMP_START400  = 15'h0100;

  // switch-read instruction codes: 517, 516 and 7404 octal
  localparam logic [11:0] OP_READ_LEFT  = 12'h14f;
  localparam logic [11:0] OP_READ_RIGHT = 12'h14e;
  localparam logic [11:0] OP_OR_SWITCH  = 12'hf04;

  // speaker follows accumulator bit 00, the most significant bit
  localparam int unsigned SPEAKER_BIT   = 11;
  localparam int unsigned DLY_W         = 16;

  typedef enum logic [2:0] {
    OCC_TP_IDLE, OCC_TP_SEARCH, OCC_TP_BLOCK, OCC_TP_CHECK, OCC_TP_TURN
  } occ_tape_t;

  // address increment: 10-bit wrap in native mode, 12-bit otherwise
  function automatic logic [11:0] occ_ma_incr(input logic [11:0] ma, input logic native);
    logic [9:0] low;
    low = ma[9:0] + 10'h001;
    if (native) begin
      return {ma[11:10], low};
    end
    return ma + 12'h001;
  endfunction : occ_ma_incr

endpackage : occ_pkg

// ### src/occ_key_if.sv
interface occ_key_if;
  logic [occ_pkg::KEY_N-1:0] lvl;
  logic [occ_pkg::KEY_N-1:0] pls;

  modport drv (output lvl, output pls);
  modport snk (input lvl, input pls);
endinterface : occ_key_if

// ### src/occ_key_pulse.sv
// two-stage synchroniser per key, then a rising-edge one-shot
module occ_key_pulse (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [occ_pkg::KEY_N-1:0] key_raw_i,
  occ_key_if.drv                         kif
);
  logic [occ_pkg::KEY_N-1:0] s1_q;
  logic [occ_pkg::KEY_N-1:0] s2_q;
  logic [occ_pkg::KEY_N-1:0] s3_q;
  logic [occ_pkg::KEY_N-1:0] pls_q;

  // RULE_23 one pulse per press
  wire  [occ_pkg::KEY_N-1:0] rise = s2_q & ~s3_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pls_q <= '0;
    end else begin
      s1_q  <= key_raw_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pls_q <= rise;
    end
  end

  assign kif.lvl = s2_q;
  assign kif.pls = pls_q;
endmodule : occ_key_pulse

// ### src/occ_console.sv
// How it works
// RULE_01 - preset: halt tape pause, mode, fields 2/3
// RULE_02 - preset emits processor and bus init pulses
// RULE_03 - execute one instruction from switch words
// RULE_04 - start at 20, banked or absolute
// RULE_05 - start at 400, banked or absolute
// RULE_06 - launch at segment plus left switches
// RULE_07 - resume continues stopped processor unchanged
// RULE_08 - view loads address, shows memory word
// RULE_09 - view-next increments address, shows word
// RULE_10 - deposit loads address, writes right switches
// RULE_11 - deposit-advance writes, increments, shows word
// RULE_12 - auto-restart flop restarts after delay
// RULE_13 - auto-restart cleared by listed conditions
// RULE_14 - code 517 loads left switches
// RULE_15 - code 516 or 7404 loads right switches
// RULE_16 - stop switch halts after each instruction
// RULE_17 - single-step clears run every cycle
// RULE_18 - fetch-address match stops processor
// RULE_19 - execute-address match stops processor
// RULE_20 - panel lock ignores keys while running (a held stop key still halts here)
// RULE_21 - tape processor state lamps driven
// RULE_22 - speaker follows accumulator bit 00
// RULE_23 - each key press gives one pulse
module occ_console (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] key_raw_i,
  input  wire logic        mode_sel_i,
  input  wire logic        step_sw_i,
  input  wire logic        fstop_sw_i,
  input  wire logic        estop_sw_i,
  input  wire logic        lock_cw_i,
  input  wire logic [11:0] left_sw_i,
  input  wire logic [11:0] right_sw_i,
  input  wire logic [2:0]  seg_sw_i,
  input  wire logic [5:0]  sense_sw_i,
  input  wire logic [15:0] restart_delay_i,
  input  wire logic        cpu_run_i,
  input  wire logic        cpu_native_i,
  input  wire logic        cpu_fetch_i,
  input  wire logic        cpu_cycle_end_i,
  input  wire logic        cpu_instr_end_i,
  input  wire logic [14:0] cpu_ma_i,
  input  wire logic        cpu_halt_instr_i,
  input  wire logic        cpu_instr_exec_i,
  input  wire logic [11:0] cpu_instr_i,
  input  wire logic        cpu_tape_pause_i,
  input  wire logic [11:0] cpu_ac_i,
  input  wire logic        mem_ack_i,
  input  wire logic [11:0] mem_rdata_i,
  input  wire logic [2:0]  tape_state_i,
  input  wire logic        tape_op_active_i,
  input  wire logic        wide_address_mode_i,
  input  wire logic        no_stall_mode_i,
  input  wire logic        mark_flag_i,
  input  wire logic [2:0]  tape_instr_i,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [14:0]      mem_addr_o,
  output logic [11:0]      mem_wdata_o,
  output logic             preset_o,
  output logic             bus_init_o,
  output logic             pause_halt_o,
  output logic             mode_native_o,
  output logic [4:0]       instr_segment_o,
  output logic [4:0]       data_segment_reg_o,
  output logic             start_o,
  output logic [14:0]      start_addr_o,
  output logic             resume_o,
  output logic             run_clear_o,
  output logic             do_o,
  output logic [11:0]      do_word1_o,
  output logic [11:0]      do_word2_o,
  output logic             ac_load_o,
  output logic [11:0]      ac_data_o,
  output logic [11:0]      memory_address_reg_o,
  output logic [11:0]      memory_buffer_reg_o,
  output logic             auto_restart_o,
  output logic [5:0]       sense_o,
  output logic [4:0]       lamp_tape_state_o,
  output logic             lamp_tape_op_active_o,
  output logic             lamp_wide_address_mode_o,
  output logic             lamp_no_stall_mode_o,
  output logic             lamp_mark_flag_o,
  output logic [2:0]       lamp_tape_instr_o,
  output logic             speaker_o
);
  typedef enum logic [1:0] {OCC_ST_IDLE, OCC_ST_RD, OCC_ST_WR, OCC_ST_DO} occ_st_t;
  occ_key_if kif ();
  occ_key_pulse u_keys (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .key_raw_i  (key_raw_i),
    .kif        (kif)
  );
  occ_st_t                   st_q;
  logic [3:0]                op_q;
  logic [11:0]               ma_q;
  logic [11:0]               mb_q;
  logic [14:0]               addr_q;
  logic [11:0]               wdata_q;
  logic                      mode_q;
  logic [4:0]                if_q;
  logic [4:0]                df_q;
  logic                      auto_q;
  logic                      pend_q;
  logic [3:0]                rk_q;
  logic [occ_pkg::DLY_W-1:0] dly_q;
  logic                      preset_q;
  logic                      halt_q;
  logic                      start_q;
  logic [14:0]               saddr_q;
  logic                      resume_q;
  logic                      rclr_q;
  logic                      do_q;
  logic                      acld_q;
  logic [11:0]               acd_q;
  logic [5:0]                sense_q;
  logic [4:0]                tlamp_q;
  logic [6:0]                misc_q;
  logic                      spk_q;
  // RULE_20 key pulses dead while locked and running; stop key level still halts
  wire                       locked = lock_cw_i & cpu_run_i;
  wire [occ_pkg::KEY_N-1:0]  kp     = kif.pls & {occ_pkg::KEY_N{~locked}};
  wire                       fire   = pend_q & (dly_q == 16'h0001) & ~cpu_run_i;
  wire [occ_pkg::KEY_N-1:0]  rsel   = occ_pkg::KEY_N'(1) << rk_q;
  wire [occ_pkg::KEY_N-1:0]  act    = kp | (fire ? rsel : '0);
  wire                       ready  = (st_q == OCC_ST_IDLE) & ~cpu_run_i & ~act[occ_pkg::K_PRESET];
  wire [14:0]                sw_adr = {seg_sw_i, left_sw_i};
  wire                       sw_hit = (cpu_ma_i == sw_adr);
  wire [11:0]                ma_inc = occ_pkg::occ_ma_incr(ma_q, cpu_native_i);
  // RULE_17 single-step stop each cycle
  wire stop_step = cpu_cycle_end_i & step_sw_i;
  // RULE_18 fetch-address match
  wire stop_f    = cpu_cycle_end_i & fstop_sw_i & cpu_fetch_i & sw_hit;
  // RULE_19 non-fetch address match
  wire stop_e    = cpu_cycle_end_i & estop_sw_i & ~cpu_fetch_i & sw_hit;
  // RULE_16 stop after every instruction
  wire stop_ins  = cpu_instr_end_i & kif.lvl[occ_pkg::K_STOP];
  wire stop_any  = cpu_run_i & (stop_step | stop_f | stop_e | stop_ins);
  wire stop_auto = cpu_run_i & (stop_step | stop_f | stop_e);
  wire do_done   = (st_q == OCC_ST_DO) & cpu_instr_end_i;
  wire step_end  = (st_q == OCC_ST_RD) & mem_ack_i
                 & (op_q == 4'(occ_pkg::K_VIEW_NEXT) || op_q == 4'(occ_pkg::K_DEP_ADV));
  wire arm       = auto_q & (stop_auto | step_end | do_done);
  // RULE_13 auto-restart clear causes
  wire auto_clr  = (kp[occ_pkg::K_STOP] & cpu_run_i)
                 | ((kp[occ_pkg::K_DO] | kp[occ_pkg::K_DEP_ADV] | kp[occ_pkg::K_VIEW_NEXT])
                    & ~kif.lvl[occ_pkg::K_AUTO])
                 | cpu_halt_instr_i | act[occ_pkg::K_PRESET];
  // RULE_14 left switch read instruction
  wire rd_left   = cpu_native_i & (cpu_instr_i == occ_pkg::OP_READ_LEFT);
  // RULE_15 right switch read instructions
  wire rd_right  = cpu_native_i ? (cpu_instr_i == occ_pkg::OP_READ_RIGHT)
                                : (cpu_instr_i == occ_pkg::OP_OR_SWITCH);
  // RULE_04 start at 20
  wire [14:0] a20  = cpu_native_i ? {if_q, occ_pkg::NAT_START20} : occ_pkg::CMP_START20;
  // RULE_05 start at 400
  wire [14:0] a400 = cpu_native_i ? {if_q, occ_pkg::NAT_START400} : occ_pkg::CMP_START400;
  wire        go20  = ready & act[occ_pkg::K_START20];
  wire        go400 = ready & act[occ_pkg::K_START400];
  wire        golau = ready & act[occ_pkg::K_LAUNCH];
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i || act[occ_pkg::K_PRESET]) begin
      st_q    <= OCC_ST_IDLE;
      op_q    <= 4'h0;
      addr_q  <= 15'h0000;
      wdata_q <= 12'h000;
      do_q    <= 1'b0;
      if (!rst_n_i) begin
        ma_q <= 12'h000;
        mb_q <= 12'h000;
      end
    end else begin
      do_q <= 1'b0;
      case (st_q)
        OCC_ST_IDLE: begin
          if (ready && act[occ_pkg::K_VIEW]) begin
            // RULE_08 view location
            ma_q   <= left_sw_i;
            addr_q <= sw_adr;
            op_q   <= 4'(occ_pkg::K_VIEW);
            st_q   <= OCC_ST_RD;
          end else if (ready && act[occ_pkg::K_VIEW_NEXT]) begin
            // RULE_09 view next location
            ma_q   <= ma_inc;
            addr_q <= {seg_sw_i, ma_inc};
            op_q   <= 4'(occ_pkg::K_VIEW_NEXT);
            st_q   <= OCC_ST_RD;
          end else if (ready && act[occ_pkg::K_DEPOSIT]) begin
            // RULE_10 deposit at switch address
            ma_q    <= left_sw_i;
            addr_q  <= sw_adr;
            wdata_q <= right_sw_i;
            op_q    <= 4'(occ_pkg::K_DEPOSIT);
            st_q    <= OCC_ST_WR;
          end else if (ready && act[occ_pkg::K_DEP_ADV]) begin
            // RULE_11 deposit at held address
            addr_q  <= {seg_sw_i, ma_q};
            wdata_q <= right_sw_i;
            op_q    <= 4'(occ_pkg::K_DEP_ADV);
            st_q    <= OCC_ST_WR;
          end else if (ready && act[occ_pkg::K_DO]) begin
            // RULE_03 one instruction from switches
            do_q <= 1'b1;
            op_q <= 4'(occ_pkg::K_DO);
            st_q <= OCC_ST_DO;
          end
        end
        OCC_ST_WR: begin
          if (mem_ack_i) begin
            mb_q <= wdata_q;
            st_q <= OCC_ST_IDLE;
            if (op_q == 4'(occ_pkg::K_DEP_ADV)) begin
              // RULE_11 advance then show
              ma_q   <= ma_inc;
              addr_q <= {addr_q[14:12], ma_inc};
              st_q   <= OCC_ST_RD;
            end
          end
        end
        OCC_ST_RD: begin
          if (mem_ack_i) begin
            mb_q <= mem_rdata_i;
            st_q <= OCC_ST_IDLE;
          end
        end
        OCC_ST_DO: st_q <= cpu_instr_end_i ? OCC_ST_IDLE : OCC_ST_DO;
        default: st_q <= OCC_ST_IDLE;
      endcase
    end
  end
  // preset, start, resume, switch reads, lamps and speaker
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_q   <= occ_pkg::MODE_RST;
      if_q     <= occ_pkg::IF_PRESET;
      df_q     <= occ_pkg::DF_PRESET;
      preset_q <= 1'b0;
      halt_q   <= 1'b0;
      start_q  <= 1'b0;
      saddr_q  <= 15'h0000;
      resume_q <= 1'b0;
      rclr_q   <= 1'b0;
      acld_q   <= 1'b0;
      acd_q    <= 12'h000;
      sense_q  <= 6'h00;
      tlamp_q  <= 5'h00;
      misc_q   <= 7'h00;
      spk_q    <= 1'b0;
    end else begin
      preset_q <= act[occ_pkg::K_PRESET];
      // RULE_01 halt tape pause on preset
      halt_q   <= act[occ_pkg::K_PRESET] & cpu_tape_pause_i;
      if (act[occ_pkg::K_PRESET]) begin
        // RULE_01 mode and segment preset
        mode_q <= mode_sel_i;
        if_q   <= occ_pkg::IF_PRESET;
        df_q   <= occ_pkg::DF_PRESET;
      end
      start_q <= go20 | go400 | golau;
      if (go20) begin
        saddr_q <= a20;
      end else if (go400) begin
        saddr_q <= a400;
      end else if (golau) begin
        // RULE_06 launch from switch address
        saddr_q <= sw_adr;
      end
      // RULE_07 resume from current state
      resume_q <= ready & act[occ_pkg::K_RESUME];
      rclr_q   <= stop_any;
      acld_q   <= cpu_instr_exec_i & (rd_left | rd_right);
      acd_q    <= rd_left ? left_sw_i : right_sw_i;
      // RULE_20 sense switches stay live
      sense_q  <= sense_sw_i;
      // RULE_21 tape processor lamps
      tlamp_q  <= (tape_state_i <= 3'(occ_pkg::OCC_TP_TURN)) ? (5'h01 << tape_state_i) : 5'h00;
      misc_q   <= {tape_op_active_i, wide_address_mode_i, no_stall_mode_i, mark_flag_i, tape_instr_i};
      // RULE_22 speaker from accumulator bit 00
      spk_q    <= cpu_ac_i[occ_pkg::SPEAKER_BIT];
    end
  end
  // RULE_12 auto-restart flop and delay
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      auto_q <= 1'b0;
      pend_q <= 1'b0;
      rk_q   <= 4'h0;
      dly_q  <= '0;
    end else begin
      if (kp[occ_pkg::K_AUTO]) begin
        auto_q <= 1'b1;
      end else if (auto_clr) begin
        auto_q <= 1'b0;
      end
      if (auto_clr && !kp[occ_pkg::K_AUTO]) begin
        pend_q <= 1'b0;
      end else if (arm) begin
        pend_q <= 1'b1;
        dly_q  <= (restart_delay_i == 16'h0000) ? 16'h0001 : restart_delay_i;
        rk_q   <= stop_auto ? 4'(occ_pkg::K_RESUME) : op_q;
      end else if (fire) begin
        pend_q <= 1'b0;
      end else if (pend_q && dly_q != 16'h0001) begin
        dly_q <= dly_q - 16'h0001;
      end
    end
  end
  assign mem_req_o                = (st_q == OCC_ST_RD) | (st_q == OCC_ST_WR);
  assign mem_we_o                 = (st_q == OCC_ST_WR);
  assign mem_addr_o               = addr_q;
  assign mem_wdata_o              = wdata_q;
  // RULE_02 processor and bus init pulses
  assign {preset_o, bus_init_o}   = {2{preset_q}};
  assign pause_halt_o             = halt_q;
  assign mode_native_o            = mode_q;
  assign instr_segment_o          = if_q;
  assign data_segment_reg_o       = df_q;
  assign start_o                  = start_q;
  assign start_addr_o             = saddr_q;
  assign resume_o                 = resume_q;
  assign run_clear_o              = rclr_q;
  assign do_o                     = do_q;
  // RULE_03 second word from right switches
  assign {do_word1_o, do_word2_o} = {left_sw_i, right_sw_i};
  assign ac_load_o                = acld_q;
  assign ac_data_o                = acd_q;
  assign memory_address_reg_o     = ma_q;
  assign memory_buffer_reg_o      = mb_q;
  assign auto_restart_o           = auto_q;
  assign sense_o                  = sense_q;
  assign lamp_tape_state_o        = tlamp_q;
  assign {lamp_tape_op_active_o, lamp_wide_address_mode_o, lamp_no_stall_mode_o, lamp_mark_flag_o,
          lamp_tape_instr_o}      = misc_q;
  assign speaker_o                = spk_q;
endmodule : occ_console

// ### tb/occ_console_assertions.sv
module occ_console_assertions (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        step_sw_i,
  input wire logic        fstop_sw_i,
  input wire logic        estop_sw_i,
  input wire logic        lock_cw_i,
  input wire logic [11:0] left_sw_i,
  input wire logic [11:0] right_sw_i,
  input wire logic [2:0]  seg_sw_i,
  input wire logic        cpu_run_i,
  input wire logic        cpu_native_i,
  input wire logic        cpu_fetch_i,
  input wire logic        cpu_cycle_end_i,
  input wire logic [14:0] cpu_ma_i,
  input wire logic        cpu_instr_exec_i,
  input wire logic [11:0] cpu_instr_i,
  input wire logic [11:0] cpu_ac_i,
  input wire logic        mem_ack_i,
  input wire logic [2:0]  tape_state_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic [11:0] mem_wdata_o,
  input wire logic        preset_o,
  input wire logic        bus_init_o,
  input wire logic [4:0]  instr_segment_o,
  input wire logic [4:0]  data_segment_reg_o,
  input wire logic        start_o,
  input wire logic        resume_o,
  input wire logic        run_clear_o,
  input wire logic        do_o,
  input wire logic        ac_load_o,
  input wire logic [11:0] ac_data_o,
  input wire logic [4:0]  lamp_tape_state_o,
  input wire logic        speaker_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_preset_fields: assert property (preset_o |-> instr_segment_o == occ_pkg::IF_PRESET
    && data_segment_reg_o == occ_pkg::DF_PRESET) else $error("preset segment values wrong");
  a_preset_init: assert property (preset_o == bus_init_o) else $error("bus init not with preset");
  a_pulse_once: assert property (preset_o |=> !preset_o) else $error("preset pulse too long");
  a_left_read: assert property (cpu_instr_exec_i && cpu_native_i && cpu_instr_i == occ_pkg::OP_READ_LEFT
    |=> ac_load_o && ac_data_o == $past(left_sw_i)) else $error("left switch read wrong");
  a_right_read: assert property (cpu_instr_exec_i && (cpu_native_i ? cpu_instr_i == occ_pkg::OP_READ_RIGHT
    : cpu_instr_i == occ_pkg::OP_OR_SWITCH) |=> ac_load_o && ac_data_o == $past(right_sw_i))
    else $error("right switch read wrong");
  a_step_stop: assert property (cpu_run_i && step_sw_i && cpu_cycle_end_i
    |=> run_clear_o) else $error("single step did not stop");
  a_fetch_stop: assert property (cpu_run_i && fstop_sw_i && cpu_fetch_i
    && cpu_cycle_end_i && cpu_ma_i == {seg_sw_i, left_sw_i} |=> run_clear_o) else $error("fetch stop missed");
  a_exec_stop: assert property (cpu_run_i && estop_sw_i && !cpu_fetch_i
    && cpu_cycle_end_i && cpu_ma_i == {seg_sw_i, left_sw_i} |=> run_clear_o) else $error("exec stop missed");
  a_lock_keys: assert property (lock_cw_i && cpu_run_i && $past(lock_cw_i && cpu_run_i)
    |-> !(start_o || resume_o || do_o || preset_o)) else $error("key acted under panel lock");
  a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
    && $stable(mem_we_o) && $stable(mem_wdata_o)) else $error("memory request changed early");
  a_speaker_bit: assert property ($past(rst_n_i) |-> speaker_o == $past(cpu_ac_i[11]))
    else $error("speaker not from accumulator");
  a_tape_lamp: assert property ($past(rst_n_i) && $past(tape_state_i) < 3'h5
    |-> lamp_tape_state_o == 5'h01 << $past(tape_state_i)) else $error("tape state lamp wrong");

  c_preset: cover property (preset_o);
  c_stop: cover property (run_clear_o);
  c_ac: cover property (ac_load_o);
  c_write: cover property (mem_req_o && mem_we_o && mem_ack_i);
endmodule : occ_console_assertions

bind occ_console occ_console_assertions u_chk (.*);

// ### tb/occ_mem_model.sv
// memory behind the console, ack after lat_i extra cycles
module occ_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [14:0] addr_i,
  input  wire logic [11:0] wdata_i,
  input  wire logic [1:0]  lat_i,
  output logic             ack_o,
  output logic [11:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] m [0:32767];
  logic [1:0]  cnt_q = 2'h0;
  initial ack_o = 1'b0;
  initial rdata_o = 12'h000;
  wire hit = req_i && !ack_o && cnt_q == lat_i;
  always @(posedge clk_i) begin
    ack_o <= hit;
    // read data is only valid with ack
    rdata_o <= hit ? m[addr_i] : ~rdata_o;
    cnt_q <= (req_i && !ack_o && !hit) ? cnt_q + 2'h1 : 2'h0;
    if (hit && we_i) m[addr_i] <= wdata_i;
  end
endmodule : occ_mem_model

// ### tb/test_occ_console.sv
module test_occ_console;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'b0, rst_n_i, mode_sel_i, step_sw_i, fstop_sw_i, estop_sw_i, lock_cw_i, cpu_run_i;
  logic cpu_native_i, cpu_fetch_i, cpu_cycle_end_i, cpu_instr_end_i, cpu_halt_instr_i, cpu_instr_exec_i;
  logic cpu_tape_pause_i, mem_ack_i, tape_op_active_i, wide_address_mode_i, no_stall_mode_i, mark_flag_i;
  logic [11:0] left_sw_i, right_sw_i, cpu_instr_i, cpu_ac_i, mem_rdata_i;
  logic [11:0] mem_wdata_o, do_word1_o, do_word2_o, ac_data_o, memory_address_reg_o, memory_buffer_reg_o;
  logic [14:0] cpu_ma_i, mem_addr_o, start_addr_o;
  logic [15:0] restart_delay_i = 16'h0003;
  logic [occ_pkg::KEY_N-1:0] key_raw_i;
  logic [2:0]  seg_sw_i, tape_state_i, tape_instr_i, lamp_tape_instr_o;
  logic [5:0]  sense_sw_i, sense_o;
  logic [4:0]  instr_segment_o, data_segment_reg_o, lamp_tape_state_o;
  logic [1:0]  lat = 2'h0;
  logic mem_req_o, mem_we_o, preset_o, bus_init_o, pause_halt_o, mode_native_o, start_o, resume_o;
  logic run_clear_o, do_o, ac_load_o, auto_restart_o, lamp_tape_op_active_o, lamp_wide_address_mode_o;
  logic lamp_no_stall_mode_o, lamp_mark_flag_o, speaker_o;
  int num_errors = 0, checked = 0, n_pre = 0, n_pause = 0, n_start = 0, n_res = 0, n_rc = 0, n_do = 0;
  int s;

  occ_console DUT (.*);
  occ_mem_model u_mem (.clk_i(core_clk_i), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    n_pre <= n_pre + preset_o;
    n_pause <= n_pause + pause_halt_o;
    n_start <= n_start + start_o;
    n_res <= n_res + resume_o;
    n_rc <= n_rc + run_clear_o;
    n_do <= n_do + do_o;
  end

  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc

  task automatic press(input int k);
    int i;
    @(posedge core_clk_i) key_raw_i[k] <= 1'b1;
    cyc(12);
    key_raw_i[k] <= 1'b0;
    for (i = 0; i < 40 && mem_req_o !== 1'b0; i++) cyc(1);
    if (mem_req_o !== 1'b0) begin
      num_errors++;
      results();
    end
    cyc(4);
  endtask : press

  initial begin
    {rst_n_i, step_sw_i, fstop_sw_i, estop_sw_i, lock_cw_i, cpu_run_i, cpu_fetch_i, cpu_cycle_end_i} = '0;
    {cpu_instr_end_i, cpu_halt_instr_i, cpu_instr_exec_i, cpu_tape_pause_i, tape_op_active_i} = '0;
    {wide_address_mode_i, no_stall_mode_i, mark_flag_i, key_raw_i, cpu_instr_i, cpu_ac_i, cpu_ma_i} = '0;
    {left_sw_i, right_sw_i, seg_sw_i, tape_state_i, tape_instr_i, sense_sw_i} = '0;
    {mode_sel_i, cpu_native_i} = 2'h3;
    u_mem.m[15'h5400] = 12'h5a5;
    u_mem.m[15'h5123] = 12'h321;
    u_mem.m[15'h5000] = 12'h0f0;
    cyc(16);
    rst_n_i <= 1'b1;
    cyc(2);
    chk(instr_segment_o, 15'h0002);
    chk(data_segment_reg_o, 15'h0003);
    for (int m = 0; m < 2; m++) begin
      mode_sel_i <= m[0];
      cpu_native_i <= m[0];
      cpu_tape_pause_i <= !m[0];
      press(occ_pkg::K_PRESET);
      chk(15'(n_pre), 15'(m + 1));
      chk(15'(n_pause), 15'h0001);
      chk(mode_native_o, m[0]);
      press(occ_pkg::K_START20);
      chk(start_addr_o, m ? 15'h0810 : 15'h0010);
      press(occ_pkg::K_START400);
      chk(start_addr_o, m ? 15'h0900 : 15'h0100);
    end
    left_sw_i <= 12'h2aa;
    seg_sw_i <= 3'h6;
    press(occ_pkg::K_LAUNCH);
    chk(start_addr_o, 15'h62aa);
    press(occ_pkg::K_RESUME);
    chk(15'(n_res), 15'h0001);
    chk(start_addr_o, 15'h62aa);
    lock_cw_i <= 1'b1;
    cpu_run_i <= 1'b1;
    sense_sw_i <= 6'h2d;
    press(occ_pkg::K_START20);
    chk(15'(n_start), 15'h0005);
    chk(sense_o, 15'h002d);
    lock_cw_i <= 1'b0;
    cpu_run_i <= 1'b0;
    left_sw_i <= 12'h7ff;
    seg_sw_i <= 3'h5;
    right_sw_i <= 12'habc;
    press(occ_pkg::K_DEPOSIT);
    chk(memory_address_reg_o, 15'h07ff);
    chk(u_mem.m[15'h57ff], 15'h0abc);
    lat <= 2'h3;
    right_sw_i <= 12'h135;
    press(occ_pkg::K_DEP_ADV);
    chk(u_mem.m[15'h57ff], 15'h0135);
    chk(memory_address_reg_o, 15'h0400);
    chk(memory_buffer_reg_o, 15'h05a5);
    lat <= 2'h1;
    left_sw_i <= 12'h123;
    press(occ_pkg::K_VIEW);
    chk(memory_address_reg_o, 15'h0123);
    chk(memory_buffer_reg_o, 15'h0321);
    for (int m = 0; m < 2; m++) begin
      cpu_native_i <= m[0];
      left_sw_i <= m ? 12'h7ff : 12'hfff;
      press(occ_pkg::K_VIEW);
      press(occ_pkg::K_VIEW_NEXT);
      chk(memory_address_reg_o, m ? 15'h0400 : 15'h0000);
      chk(memory_buffer_reg_o, m ? 15'h05a5 : 15'h00f0);
    end
    press(occ_pkg::K_AUTO);
    chk(auto_restart_o, 15'h0001);
    left_sw_i <= occ_pkg::OP_READ_LEFT;
    right_sw_i <= 12'h246;
    press(occ_pkg::K_DO);
    chk(15'(n_do), 15'h0001);
    chk(do_word1_o, occ_pkg::OP_READ_LEFT);
    chk(do_word2_o, 15'h0246);
    chk(auto_restart_o, 15'h0000);
    cpu_run_i <= 1'b1;
    cpu_instr_end_i <= 1'b1;
    cyc(1);
    {cpu_run_i, cpu_instr_end_i} <= 2'h0;
    press(occ_pkg::K_AUTO);
    cpu_halt_instr_i <= 1'b1;
    cyc(1);
    cpu_halt_instr_i <= 1'b0;
    cyc(2);
    chk(auto_restart_o, 15'h0000);
    press(occ_pkg::K_AUTO);
    step_sw_i <= 1'b1;
    cpu_run_i <= 1'b1;
    cyc(6);
    cpu_cycle_end_i <= 1'b1;
    cyc(1);
    {cpu_run_i, cpu_cycle_end_i} <= 2'h0;
    cyc(16);
    chk(15'(n_rc), 15'h0001);
    chk(15'(n_res), 15'h0002);
    step_sw_i <= 1'b0;
    cpu_run_i <= 1'b1;
    key_raw_i[occ_pkg::K_STOP] <= 1'b1;
    cyc(8);
    cpu_instr_end_i <= 1'b1;
    cyc(1);
    cpu_instr_end_i <= 1'b0;
    cyc(3);
    chk(15'(n_rc), 15'h0002);
    chk(auto_restart_o, 15'h0000);
    key_raw_i[occ_pkg::K_STOP] <= 1'b0;
    cpu_ma_i <= 15'h514f;
    for (int f = 0; f < 2; f++) begin
      {fstop_sw_i, estop_sw_i, cpu_fetch_i} <= {f[0], !f[0], f[0]};
      cyc(6);
      cpu_cycle_end_i <= 1'b1;
      cyc(1);
      cpu_cycle_end_i <= 1'b0;
      cyc(2);
      chk(15'(n_rc), 15'(f + 3));
    end
    cpu_run_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      cpu_native_i <= (i < 2);
      cpu_instr_i <= i == 0 ? occ_pkg::OP_READ_LEFT : i == 1 ? occ_pkg::OP_READ_RIGHT : occ_pkg::OP_OR_SWITCH;
      cpu_instr_exec_i <= 1'b1;
      cyc(1);
      cpu_instr_exec_i <= 1'b0;
      cyc(2);
      chk(ac_data_o, i == 0 ? occ_pkg::OP_READ_LEFT : 15'h0246);
    end
    {tape_op_active_i, wide_address_mode_i, no_stall_mode_i, mark_flag_i, tape_instr_i} <= 7'h7d;
    cpu_ac_i <= 12'h800;
    for (s = 0; s < 5; s++) begin
      tape_state_i <= s[2:0];
      cyc(3);
      chk(lamp_tape_state_o, 15'h0001 << s);
    end
    chk({lamp_tape_op_active_o, lamp_wide_address_mode_o, lamp_no_stall_mode_o, lamp_mark_flag_o,
      lamp_tape_instr_o}, 15'h007d);
    chk(speaker_o, 15'h0001);
    results();
  end
endmodule : test_occ_console
